/* common/alert_rate_pkg.sv */
/*
 * Constants shared by the alarm-mask and sampling-rate register block:
 * register indices, reset values, field positions and timing figures.
 * Assumes a single 125 MHz clock domain and 8-bit registers.
 */
package alert_rate_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_STATUS  = 8'h02; // Latched alarm status
    localparam logic [7:0] IDX_CONFIG  = 8'h03; // Standby and pin mode
    localparam logic [7:0] IDX_RATE    = 8'h04; // sampling_rate_select
    localparam logic [7:0] IDX_TRIGGER = 8'h0f; // single_conversion_trigger
    localparam logic [7:0] IDX_MASK    = 8'h16; // alarm_output_mask
    localparam int         ADDR_W      = 10;    // Byte address width

    // ****************************************************************
    // Reset values and field layouts
    // ****************************************************************
    localparam logic [7:0] RATE_RESET   = 8'h08; // 16 Hz after reset
    localparam logic [7:0] RATE_CODE_MAX = 8'h09; // 32 Hz code
    localparam logic [7:0] MASK_RESET   = 8'h00; // All alarms enabled
    localparam logic [7:0] MASK_ONES    = 8'ha4; // Unused bits 7, 5, 2
    localparam logic [7:0] MASK_RW      = 8'h5b; // Writable mask bits
    localparam logic [7:0] ALERT_SRC    = 8'h5b; // Alarms that may alert
    localparam logic [7:0] CONFIG_RESET = 8'h00; // Running, alert mode
    localparam int BIT_BUSY        = 7;
    localparam int BIT_LOCAL_HIGH  = 6;
    localparam int BIT_REMOTE_HIGH = 4;
    localparam int BIT_REMOTE_LOW  = 3;
    localparam int BIT_DIODE_FAULT = 2;
    localparam int BIT_CRIT        = 1;
    localparam int BIT_FAN         = 0;
    localparam int CFG_STANDBY     = 0; // 1: low-power idle
    localparam int CFG_FAN_INPUT   = 1; // 1: shared pin is fan input

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_FREQ_HZ     = 125000000; // Reference clock
    localparam int FASTEST_RATE_HZ = 32;        // Top sampling rate
    localparam int FASTEST_PERIOD_CYCLES = CLK_FREQ_HZ / FASTEST_RATE_HZ;

    // ****************************************************************
    // Conversion sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        CONV_IDLE  = 3'b001,
        CONV_START = 3'b010,
        CONV_BUSY  = 3'b100
    } conv_state_t;

endpackage

/* design/alarm_latch.sv */
/*
 * Bank of sticky alarm flags. A flag sets while its condition holds and
 * a read clears it only where the condition has gone away.
 * Assumes conditions and clear requests are synchronous to the clock.
 */
`timescale 1ns/1ps

module alarm_latch #(
    parameter int WIDTH = 8 // Number of flags
) (
    input  wire logic             i_clk,    // Block clock
    input  wire logic             i_resetn, // Async reset, active low
    input  wire logic [WIDTH-1:0] i_cond,   // Live alarm conditions
    input  wire logic [WIDTH-1:0] i_clear,  // Flags seen by a read
    output logic      [WIDTH-1:0] o_flags   // Latched flags
);

    // ********
    // Flag storage
    // ********
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_flag
            // A live condition beats the clear, so no event is lost
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_flags[g] <= 1'b0;
                end else if (i_cond[g]) begin
                    o_flags[g] <= 1'b1;
                end else if (i_clear[g]) begin
                    o_flags[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

/* design/rate_timer.sv */
/*
 * Free-running sample-period timer. The code picks a period that halves
 * per step up to the fastest code; larger codes stay at the fastest.
 * Assumes the code is a stable register value.
 */
`timescale 1ns/1ps

module rate_timer
    import alert_rate_pkg::*;
#(
    parameter int BASE_CYCLES = 3906250 // Period at the fastest rate
) (
    input  wire logic       i_clk,    // Block clock
    input  wire logic       i_resetn, // Async reset, active low
    input  wire logic       i_run,    // Timer runs while high
    input  wire logic [7:0] i_code,   // Sampling rate code
    output logic            o_tick    // One-cycle sample request
);

    logic [31:0] count;  // Cycles into the current period
    logic [31:0] period; // Current period in cycles
    logic [3:0]  shift;  // Doublings below the fastest rate

    // ********
    // Period decode
    // ********
    // Codes past the top clamp to the fastest period
    always_comb begin
        if (i_code >= RATE_CODE_MAX) begin
            shift = 4'h0;
        end else begin
            shift = 4'(RATE_CODE_MAX - i_code);
        end
        period = 32'(BASE_CYCLES) << shift;
    end

    // ********
    // Counter
    // ********
    // Compare with >= so a shorter new period ends at once
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count  <= 32'h0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            count  <= 32'h0;
            o_tick <= 1'b0;
        end else if (count >= period - 32'h1) begin
            count  <= 32'h0;
            o_tick <= 1'b1;
        end else begin
            count  <= count + 32'h1;
            o_tick <= 1'b0;
        end
    end

endmodule

/* design/alert_mask_conversion_rate.sv */
/*
 * Alarm mask, sampling rate and single-conversion trigger registers,
 * with latched alarm status, the fault output and the conversion pacer.
 * Assumes an Avalon-MM master on the same clock and a converter that
 * answers each start pulse with one done pulse.
 */
// Notes on behaviour
// - Mask bits 7, 5, 2 read as one
// - Mask bit 6 gates local-high alarm
// - Mask bit 4 gates remote-high alarm
// - Mask bit 3 gates remote-low alarm
// - Mask bit 1 gates critical-limit alarm
// - Mask bit 0 gates fan-speed alarm
// - Rate code doubles frequency per step
// - Codes above range run at fastest
// - Rate register resets to sixteen hertz code
// - Trigger write in idle runs one conversion
// - Flags latch; read clears only vanished alarms
// - Diode fault never drives fault output
// - Fan alarm only in fan-input pin mode
`timescale 1ns/1ps

module alert_mask_conversion_rate
    import alert_rate_pkg::*;
#(
    parameter int BASE_CYCLES = FASTEST_PERIOD_CYCLES // Fastest period
) (
    input  wire logic              i_ref_clk,        // 125 MHz clock
    input  wire logic              i_resetn,         // Async reset
    input  wire logic [ADDR_W-1:0] i_avs_address,    // Byte address
    input  wire logic              i_avs_read,       // Read request
    input  wire logic              i_avs_write,      // Write request
    input  wire logic [31:0]       i_avs_writedata,  // Write data
    input  wire logic [3:0]        i_avs_byteenable, // Byte lanes
    output logic      [31:0]       o_avs_readdata,   // Read data
    output logic                   o_avs_waitrequest,// Stall master
    input  wire logic              i_local_high,     // Local over limit
    input  wire logic              i_remote_high,    // Remote over limit
    input  wire logic              i_remote_low,     // Remote under limit
    input  wire logic              i_diode_fault,    // Diode open/short
    input  wire logic              i_critical_limit, // Remote critical
    input  wire logic              i_fan_slow,       // Fan below minimum
    input  wire logic              i_conv_done,      // Conversion ended
    output logic                   o_conv_start,     // Start conversion
    output logic                   o_fan_pin_mode,   // Pin is fan input
    output logic                   o_alert_o,        // Alert pin level
    output logic                   o_alert_oe_n,     // Alert pin drive
    output logic                   o_irq             // Fault interrupt
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Byte address of a register index; used by both decoders
    function automatic logic is_reg(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
        is_reg = (addr == {idx, 2'b00});
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]  rate;        // Sampling rate code
    logic [7:0]  mask;        // Writable mask bits only
    logic [7:0]  config_reg;  // Standby and pin mode
    logic [7:0]  status;      // Latched alarms (busy excluded)
    logic [7:0]  alarm_cond;  // Live alarm conditions
    logic [7:0]  read_clear;  // Flags to clear after a read
    logic [7:0]  seen;        // Status bits returned to the read
    logic [7:0]  unmasked;    // Alarms that pass the mask
    logic        ack;         // Answer cycle of the bus access
    logic        acc_write;   // Write takes effect this edge
    logic        acc_read;    // Read completes this edge
    logic        wr_lane;     // Low byte lane written
    logic        standby;     // Low-power idle
    logic        fan_mode;    // Shared pin is fan input
    logic        tick;        // Sample period elapsed
    logic        shot_req;    // Trigger written in standby
    logic        shot_pend;   // Single conversion outstanding
    logic        busy;        // Conversion in progress
    logic [7:0]  next_rdata;  // Read value for the answer cycle
    conv_state_t state;       // Conversion sequencer
    conv_state_t next_state;  // Sequencer next state

    assign standby  = config_reg[CFG_STANDBY];
    assign fan_mode = config_reg[CFG_FAN_INPUT];
    assign busy     = (state != CONV_IDLE);

    // ****************************************************************
    // Avalon-MM slave handshake
    // ****************************************************************
    // One wait state: request seen, answered on the following edge
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
    assign acc_write = i_avs_write & ack;
    assign acc_read  = i_avs_read & ack;
    assign wr_lane   = acc_write & i_avs_byteenable[0];

    // Answer flag: high for one cycle per access
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_avs_read | i_avs_write) & ~ack;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Decode; unmapped and write-only addresses read as zero
    always_comb begin
        next_rdata = 8'h00;
        if (is_reg(i_avs_address, IDX_STATUS)) begin
            next_rdata = status;
            next_rdata[BIT_BUSY] = busy;
        end else if (is_reg(i_avs_address, IDX_CONFIG)) begin
            next_rdata = config_reg;
        end else if (is_reg(i_avs_address, IDX_RATE)) begin
            next_rdata = rate;
        end else if (is_reg(i_avs_address, IDX_MASK)) begin
            next_rdata = mask | MASK_ONES;
        end
    end

    // Read data registered in the wait cycle, stands at the answer
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_avs_readdata <= 32'h0;
        end else if (i_avs_read & ~ack) begin
            o_avs_readdata <= {24'h0, next_rdata};
        end
    end

    // Remember which flags the master saw, so a flag set during the
    // wait cycle is not cleared before anyone has read it
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            seen <= 8'h00;
        end else if (i_avs_read & ~ack) begin
            seen <= is_reg(i_avs_address, IDX_STATUS) ? status : 8'h00;
        end
    end

    assign read_clear = acc_read ? seen : 8'h00;

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    // Sampling rate code; every 8-bit value is accepted
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rate <= RATE_RESET;
        end else if (wr_lane && is_reg(i_avs_address, IDX_RATE)) begin
            rate <= i_avs_writedata[7:0];
        end
    end

    // Alarm mask; unused bits hold no state
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mask <= MASK_RESET;
        end else if (wr_lane && is_reg(i_avs_address, IDX_MASK)) begin
            mask <= i_avs_writedata[7:0] & MASK_RW;
        end
    end

    // Standby and shared-pin mode
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            config_reg <= CONFIG_RESET;
        end else if (wr_lane && is_reg(i_avs_address, IDX_CONFIG)) begin
            config_reg <= i_avs_writedata[7:0] & 8'h03;
        end
    end

    // Trigger write: value is ignored, only honoured in standby
    assign shot_req = wr_lane && standby
                      && is_reg(i_avs_address, IDX_TRIGGER);

    // ****************************************************************
    // Alarm status
    // ****************************************************************
    // Fan alarm can only exist when the pin senses the fan
    always_comb begin
        alarm_cond = 8'h00;
        alarm_cond[BIT_LOCAL_HIGH]  = i_local_high;
        alarm_cond[BIT_REMOTE_HIGH] = i_remote_high;
        alarm_cond[BIT_REMOTE_LOW]  = i_remote_low;
        alarm_cond[BIT_DIODE_FAULT] = i_diode_fault;
        alarm_cond[BIT_CRIT]        = i_critical_limit;
        alarm_cond[BIT_FAN]         = i_fan_slow & fan_mode;
    end

    alarm_latch #(
        .WIDTH (8)
    ) u_alarms (
        .i_clk    (i_ref_clk),
        .i_resetn (i_resetn),
        .i_cond   (alarm_cond),
        .i_clear  (read_clear),
        .o_flags  (status)
    );

    // ****************************************************************
    // Fault interrupt and alert pin
    // ****************************************************************
    // Diode fault is excluded from the sources whatever the mask says
    assign unmasked = status & ~mask & ALERT_SRC;
    assign o_irq    = |unmasked;

    // Open-drain pin: pulled low when alerting, released in fan mode
    // because the pin is then an input from the fan sensor
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_alert_oe_n <= 1'b1;
        end else begin
            o_alert_oe_n <= ~(o_irq & ~fan_mode);
        end
    end

    assign o_alert_o      = 1'b0;
    assign o_fan_pin_mode = fan_mode;

    // ****************************************************************
    // Sample pacing
    // ****************************************************************
    // Timer halts in standby so only the trigger starts conversions
    rate_timer #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_timer (
        .i_clk    (i_ref_clk),
        .i_resetn (i_resetn),
        .i_run    (~standby),
        .i_code   (rate),
        .o_tick   (tick)
    );

    // Single conversion request held until the sequencer takes it;
    // a second write while one is pending does not queue another
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shot_pend <= 1'b0;
        end else if (shot_req) begin
            shot_pend <= 1'b1;
        end else if (state == CONV_IDLE) begin
            shot_pend <= 1'b0;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    // A timer tick that lands mid-conversion is dropped: the converter
    // cannot run faster than it finishes
    always_comb begin
        case (state)
            CONV_IDLE: begin
                if (tick | shot_pend) begin
                    next_state = CONV_START;
                end else begin
                    next_state = CONV_IDLE;
                end
            end
            CONV_START: begin
                next_state = CONV_BUSY;
            end
            CONV_BUSY: begin
                if (i_conv_done) begin
                    next_state = CONV_IDLE;
                end else begin
                    next_state = CONV_BUSY;
                end
            end
            default: begin
                next_state = CONV_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= CONV_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Start pulse: exactly one cycle per conversion
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= (state == CONV_IDLE) && (next_state == CONV_START);
        end
    end

endmodule

/* sim/conv_model.sv */
/*
 * Behavioural converter on the far side of the conversion pacer.
 * Assumes the start pulse is one cycle wide and the clock is shared.
 */
`timescale 1ns/1ps

module conv_model #(
    parameter int DELAY = 5 // Cycles one conversion takes
) (
    input  wire logic i_clk,    // Block clock
    input  wire logic i_resetn, // Async reset, active low
    input  wire logic i_start,  // Start pulse from the block
    output logic      o_done    // One-cycle end of conversion
);
    // ********
    // One full conversion per start pulse
    // ********
    int left; // Cycles still to run, 0 when idle

    // Count down and end with a single done pulse
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            left   <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (left == 1);
            if (i_start && left == 0) begin
                left <= DELAY;
            end else if (left > 0) begin
                left <= left - 1;
            end
        end
    end
endmodule

/* sim/alert_mask_conversion_rate_chk.sv */
/*
 * Port-level assertions for the alarm mask and sampling rate block.
 * Assumes one clock domain; bound to the top module below.
 */
`timescale 1ns/1ps

module amcr_chk
    import alert_rate_pkg::*;
(
    input wire logic              i_ref_clk,         // Clock
    input wire logic              i_resetn,          // Reset
    input wire logic [ADDR_W-1:0] i_avs_address,     // Address
    input wire logic              i_avs_read,        // Read
    input wire logic              i_avs_write,       // Write
    input wire logic [31:0]       o_avs_readdata,    // Read data
    input wire logic              o_avs_waitrequest, // Stall
    input wire logic              i_local_high,      // Alarm
    input wire logic              i_remote_high,     // Alarm
    input wire logic              i_remote_low,      // Alarm
    input wire logic              i_critical_limit,  // Alarm
    input wire logic              i_fan_slow,        // Alarm
    input wire logic              o_conv_start,      // Start pulse
    input wire logic              o_fan_pin_mode,    // Pin mode
    input wire logic              o_alert_o,         // Pin data
    input wire logic              o_alert_oe_n,      // Pin drive
    input wire logic              o_irq              // Interrupt
);
    // ********
    // Bus handshake steps
    // ********
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_stalled;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_answer;
        !o_avs_waitrequest;
    endsequence
    // Alarm causes that may raise the interrupt; diode fault is absent
    wire logic cause = i_local_high | i_remote_high | i_remote_low | i_critical_limit
                       | i_fan_slow;

    // ********
    // Assertions
    // ********
    a_one_wait_state: assert property (s_stalled |=> s_answer)
        else $error("bus answer late");
    a_idle_no_stall: assert property (!(i_avs_read || i_avs_write) |-> s_answer)
        else $error("stall without request");
    a_mask_unused_ones: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address == {IDX_MASK, 2'b00} |-> (o_avs_readdata[7:0] & MASK_ONES) == MASK_ONES)
        else $error("unused mask bits not one");
    a_irq_has_cause: assert property ($rose(o_irq) |-> $past(cause) || $past(i_avs_write))
        else $error("interrupt without alarm");
    a_start_one_cycle: assert property (o_conv_start |=> !o_conv_start)
        else $error("start pulse too long");
    a_fan_mode_quiet: assert property (o_fan_pin_mode && $past(o_fan_pin_mode) |-> o_alert_oe_n)
        else $error("alert driven in fan mode");
    a_alert_tracks_irq: assert property (!o_fan_pin_mode && !$past(o_fan_pin_mode)
        |-> o_alert_oe_n == !$past(o_irq))
        else $error("alert pin not following interrupt");
    a_alert_data_low: assert property (o_alert_o == 1'b0)
        else $error("alert data not low");
endmodule

bind alert_mask_conversion_rate amcr_chk u_chk (.*);

/* sim/alert_mask_conversion_rate_test.sv */
/*
 * Self-checking bench for the alarm mask and sampling rate block.
 * Assumes the converter model answers every start pulse.
 */
`timescale 1ns/1ps

module alert_mask_conversion_rate_test;
    import alert_rate_pkg::*;
    // ********
    // Signals
    // ********
    localparam int BASE = 20;    // Short fastest period
    localparam int LIMIT = 80000; // Hang ceiling in cycles
    logic        clk = 1'b0;     // Bench clock
    logic        resetn = 1'b0;  // Reset, active low
    logic [9:0]  addr = 10'h000; // Byte address
    logic        rd = 1'b0;      // Read request
    logic        wr = 1'b0;      // Write request
    logic [31:0] wdata = 32'h0;  // Write data
    logic [7:0]  al = 8'h00;     // Alarm conditions, status layout
    logic [31:0] rdata;          // Read data
    logic        waitreq, done, start, fan_mode, alert_o, alert_oe_n, irq;
    logic [7:0]  d;              // Last read byte
    int          error_cnt = 0, compares = 0, cyc = 0, starts = 0, t0;

    alert_mask_conversion_rate #(.BASE_CYCLES(BASE)) u_dut (
        .i_ref_clk(clk), .i_resetn(resetn), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_local_high(al[6]),
        .i_remote_high(al[4]), .i_remote_low(al[3]), .i_diode_fault(al[2]),
        .i_critical_limit(al[1]), .i_fan_slow(al[0]), .i_conv_done(done),
        .o_conv_start(start), .o_fan_pin_mode(fan_mode), .o_alert_o(alert_o),
        .o_alert_oe_n(alert_oe_n), .o_irq(irq));
    conv_model u_conv (.i_clk(clk), .i_resetn(resetn), .i_start(start), .o_done(done));

    // Clock, cycle count, start pulse count and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (start === 1'b1) begin
            starts <= starts + 1;
        end
        if (cyc == LIMIT) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ********
    // Bus cycles and compare
    // ********
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        // Hold until a rising edge sees waitrequest low; data taken there
        do @(posedge clk); while (waitreq !== 1'b0);
        d = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic wait_start;
        do @(negedge clk); while (start !== 1'b1);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        bus(0, IDX_RATE, 8'h00);
        chk(d, 8'h08, "rate reset");
        bus(0, IDX_MASK, 8'h00);
        chk(d, 8'ha4, "mask reset");
        bus(1, IDX_MASK, 8'hff);
        bus(0, IDX_MASK, 8'h00);
        chk(d, 8'hff, "mask all set");
        bus(1, IDX_MASK, 8'h00);
        bus(0, IDX_MASK, 8'h00);
        chk(d, 8'ha4, "unused bits stay one");
        bus(0, 8'h3f, 8'h00);
        chk(d, 8'h00, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_masks;
        int src[5] = '{6, 4, 3, 1, 0};
        foreach (src[i]) begin
            bus(1, IDX_CONFIG, (src[i] == 0) ? 8'h02 : 8'h00);
            bus(1, IDX_MASK, 8'hff);
            @(posedge clk) al[src[i]] <= 1'b1;
            @(posedge clk) al[src[i]] <= 1'b0;
            repeat (3) @(negedge clk);
            chk(irq, 1'b0, "masked alarm");
            bus(1, IDX_MASK, ~(8'h01 << src[i]));
            repeat (2) @(negedge clk);
            chk(irq, 1'b1, "unmasked alarm");
            chk(alert_oe_n, src[i] == 0, "alert pin");
            bus(0, IDX_STATUS, 8'h00);
            chk(d[src[i]], 1'b1, "flag latched");
            @(negedge clk);
            chk(irq, 1'b0, "flag cleared");
        end
        bus(1, IDX_CONFIG, 8'h00);
        $display("test masks done");
    endtask
    task automatic t_latch;
        bus(1, IDX_MASK, 8'h00);
        @(posedge clk) al[2] <= 1'b1;
        @(posedge clk) al[2] <= 1'b0;
        repeat (3) @(negedge clk);
        chk(irq, 1'b0, "diode fault no irq");
        @(posedge clk) al[4] <= 1'b1;
        bus(0, IDX_STATUS, 8'h00);
        chk(d[4] & d[2], 1'b1, "both flags set");
        bus(0, IDX_STATUS, 8'h00);
        chk(d[4], 1'b1, "flag held while alarm");
        @(posedge clk) al[4] <= 1'b0;
        bus(0, IDX_STATUS, 8'h00);
        chk(d[4], 1'b1, "flag kept until read");
        bus(0, IDX_STATUS, 8'h00);
        chk(d[4], 1'b0, "flag gone");
        chk(irq, 1'b0, "irq gone");
        $display("test latch done");
    endtask
    task automatic t_rate;
        logic [7:0] code[6] = '{8'h00, 8'h07, 8'h08, 8'h09, 8'h0a, 8'hff};
        foreach (code[i]) begin
            bus(1, IDX_RATE, code[i]);
            bus(0, IDX_RATE, 8'h00);
            chk(d, code[i], "rate readback");
            wait_start();
            wait_start();
            t0 = cyc;
            wait_start();
            chk(cyc - t0, (code[i] > 9) ? BASE : BASE << (9 - code[i]), "period");
        end
        $display("test rate done");
    endtask
    task automatic t_trigger;
        bus(1, IDX_CONFIG, 8'h01);
        repeat (10) @(posedge clk);
        t0 = starts;
        repeat (200) @(posedge clk);
        chk(starts - t0, 0, "idle has no ticks");
        bus(1, IDX_TRIGGER, 8'h5a);
        repeat (40) @(posedge clk);
        chk(starts - t0, 1, "one conversion");
        bus(1, IDX_TRIGGER, 8'h00);
        repeat (40) @(posedge clk);
        chk(starts - t0, 2, "one more");
        bus(0, IDX_TRIGGER, 8'h00);
        chk(d, 8'h00, "trigger reads zero");
        bus(1, IDX_CONFIG, 8'h00);
        $display("test trigger done");
    endtask

    // ********
    // Sequence and verdict
    // ********
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_masks();
        t_latch();
        t_trigger();
        t_rate();
        give_verdict();
    end
endmodule
